// ==== verilog/aux_intc_consts.vh ====
// Register offsets, field positions, vectors and reset values of the auxiliary interrupt block.
`ifndef AUX_INTC_CONSTS_VH
`define AUX_INTC_CONSTS_VH
`define OFF_INPUT_MASK      20'h08014
`define OFF_PENDING_STATUS  20'h08018
`define OFF_ERROR_MASK      20'h0801C
`define OFF_EOS_ZERO        20'h09000
`define OFF_EOS_ONE         20'h0A000
`define OFF_VECTOR          20'h0F000
`define POS_ERR_MASK        6
`define POS_EXT_STATUS      20
`define POS_ERR_STATUS      19
`define POS_WAITING         8
`define VEC_ERROR           8'hE8
`define VEC_DIRECT3         8'h70
`define VEC_DIRECT2         8'h78
`define VEC_DIRECT1         8'h53
`define VEC_DIRECT0         8'h52
`define VEC_DMA_BASE        8'h47
`define VEC_DISCARD         8'hFF
`define VEC_NONE            8'h00
`define RST_MASK            4'h0
`define GNT_NONE            2'h0
`define GNT_LOCAL           2'h1
`define GNT_DMA             2'h2
`define GNT_ACK             2'h3
`endif

// ==== verilog/aux_bus_interrupt_and_arbiter.v ====
// Auxiliary bus interrupt front end, end-of-service handling and bus arbiter.
// Summary of operation
// - Mask register bits 3..0 enable the four auxiliary interrupt inputs individually.
// - Clearing a mask takes effect in step with the sampled input, avoiding spurious interrupts.
// - Mask register bit 6 and error mask bit 6 share one storage bit.
// - Error mask bit 6 gates the error input with the same synchronized disable.
// - Status shows direct-mode inputs in bits 23..20 and DMA channels in 7..0.
// - Status bit 19 shows the error input; other high bits read zero.
// - Acknowledge-mode inputs stop detecting after an interrupt until end-of-service.
// - Any read or write of an end-of-service location re-enables that input.
// - End-of-service accesses are retried while a posted auxiliary write is outstanding.
// - End-of-service bit 0 reads one if re-enable was needed; access clears it.
// - End-of-service bits 31..1 read zero and write data is ignored.
// - Vector register bits 7..0 return the highest-priority pending vector.
// - Vector register bit 8 is the interrupt-waiting flag, same as the interrupt pin.
// - Arbiter priority: local-bus master, then DMA, then interrupt acknowledge.
// - Local master never aborts a running cycle and is granted the next one.
// - A DMA channel keeps the bus while requesting, its buffer permits and the local master is not requesting.
// - DMA channels are served round-robin from channel 0 through channel 7.
// - Acknowledge is granted only after local and DMA requests idle a full cycle.
// - Inputs 0 and 1 each select direct mode or acknowledge mode.
// - An acknowledge returning vector FFh is discarded and needs no end-of-service.
// - Vector priority: error, external inputs, then DMA 0..7 as 47h down to 40h.
`timescale 1ns/10ps
`include "aux_intc_consts.vh"
module aux_bus_interrupt_and_arbiter
#(
	parameter CHANNELS = 8
)
(
	input  wire                clk_sys,
	input  wire                rst,
	input  wire                reg_rd,
	input  wire                reg_wr,
	input  wire [19:0]         reg_addr,
	input  wire [31:0]         reg_wdata,
	output reg  [31:0]         reg_rdata,
	output wire                reg_retry,
	input  wire                posted_write_busy,
	input  wire [3:0]          aux_interrupt_inputs,
	input  wire                aux_error_input,
	input  wire [1:0]          acknowledge_mode_select,
	input  wire [CHANNELS-1:0] dma_irq,
	input  wire                ack_vector_valid,
	input  wire [7:0]          ack_vector,
	output wire                irq_out,
	input  wire                local_req,
	input  wire [CHANNELS-1:0] dma_request_line,
	input  wire [CHANNELS-1:0] dma_buffer_stop,
	input  wire                cycle_done,
	output reg  [1:0]          grant_r,
	output reg  [2:0]          grant_channel_r,
	output wire                ack_req
);
	reg  [3:0]          ext_mask_r;
	reg                 err_mask_r;
	reg  [3:0]          ext_samp_r;
	reg                 err_samp_r;
	reg  [3:0]          gate_r;
	reg                 err_gate_r;
	reg  [1:0]          detect_on_r;
	reg  [1:0]          vec_held_r;
	reg  [7:0]          vec0_r;
	reg  [7:0]          vec1_r;
	reg  [1:0]          eos_flag_r;
	reg                 idle_seen_r;
	reg  [2:0]          rr_ptr_r;
	reg                 busy_r;
	reg                 ack_target_r;

	wire                sel_imr;
	wire                sel_error_input_mask;
	wire                sel_eos0;
	wire                sel_eos1;
	wire                acc;
	wire [3:0]          ext_live;
	wire [1:0]          need_ack;
	wire                dma_any;
	reg  [7:0]          vec_nxt;
	reg                 pend_nxt;
	reg  [2:0]          pick_nxt;
	reg                 pick_ok;
	integer             i;
	wire [1:0]          eos_take;
	wire                ack_take;
	wire                ack_discard;
	wire [CHANNELS-1:0] rot_elig;
	genvar              g;

	assign acc      = reg_rd | reg_wr;
	assign sel_imr  = reg_addr == `OFF_INPUT_MASK;
	assign sel_error_input_mask = reg_addr == `OFF_ERROR_MASK;
	assign sel_eos0 = reg_addr == `OFF_EOS_ZERO;
	assign sel_eos1 = reg_addr == `OFF_EOS_ONE;
	assign reg_retry = acc & (sel_eos0 | sel_eos1) & posted_write_busy;
	assign eos_take  = {2{acc & ~posted_write_busy}} & {sel_eos1, sel_eos0};
	assign ack_take  = ack_vector_valid & (grant_r == `GNT_ACK);
	assign ack_discard = ack_take & (ack_vector == `VEC_DISCARD);

	// Inputs pass only while the gate, updated on the sample edge, is open.
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			ext_mask_r <= `RST_MASK;
			err_mask_r <= 1'b0;
			ext_samp_r <= 4'h0;
			err_samp_r <= 1'b0;
			gate_r     <= 4'h0;
			err_gate_r <= 1'b0;
		end
		else
		begin
			if (reg_wr & sel_imr)
			begin
				ext_mask_r <= reg_wdata[3:0];
				err_mask_r <= reg_wdata[`POS_ERR_MASK];
			end
			else if (reg_wr & sel_error_input_mask)
				err_mask_r <= reg_wdata[`POS_ERR_MASK];
			ext_samp_r <= aux_interrupt_inputs;
			err_samp_r <= aux_error_input;
			gate_r     <= ext_mask_r;
			err_gate_r <= err_mask_r;
		end
	end

	generate
		for (g = 0; g < 4; g = g + 1)
		begin : live_gen
			assign ext_live[g] = ext_samp_r[g] & gate_r[g];
		end
	endgenerate

	// Acknowledge-mode detection, vector capture and end-of-service.
	assign need_ack = acknowledge_mode_select & ext_live[1:0] & detect_on_r;
	assign ack_req  = |need_ack;

	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			detect_on_r  <= 2'b11;
			vec_held_r   <= 2'b00;
			vec0_r       <= `VEC_NONE;
			vec1_r       <= `VEC_NONE;
			eos_flag_r   <= 2'b00;
		end
		else
		begin
			if (ack_take)
			begin
				if (~ack_target_r)
				begin
					detect_on_r[0] <= 1'b0;
					eos_flag_r[0]  <= 1'b1;
					vec0_r         <= ack_vector;
					vec_held_r[0]  <= ack_vector != `VEC_DISCARD;
				end
				else
				begin
					detect_on_r[1] <= 1'b0;
					eos_flag_r[1]  <= 1'b1;
					vec1_r         <= ack_vector;
					vec_held_r[1]  <= ack_vector != `VEC_DISCARD;
				end
			end
			if (ack_discard)
			begin
				if (~ack_target_r)
				begin
					detect_on_r[0] <= 1'b1;
					eos_flag_r[0]  <= 1'b0;
				end
				else
				begin
					detect_on_r[1] <= 1'b1;
					eos_flag_r[1]  <= 1'b0;
				end
			end
			if (eos_take[0])
			begin
				detect_on_r[0] <= 1'b1;
				vec_held_r[0]  <= 1'b0;
				eos_flag_r[0]  <= 1'b0;
			end
			if (eos_take[1])
			begin
				detect_on_r[1] <= 1'b1;
				vec_held_r[1]  <= 1'b0;
				eos_flag_r[1]  <= 1'b0;
			end
		end
	end

	// The acknowledge target is frozen while an acknowledge cycle runs.
	always @(posedge clk_sys)
	begin
		if (rst)
			ack_target_r <= 1'b0;
		else if (grant_r != `GNT_ACK)
			ack_target_r <= ~need_ack[0];
	end

	// Highest-priority pending vector.
	always @*
	begin
		vec_nxt  = `VEC_NONE;
		pend_nxt = 1'b1;
		if (err_samp_r & err_gate_r)
			vec_nxt = `VEC_ERROR;
		else if (vec_held_r[0])
			vec_nxt = vec0_r;
		else if (vec_held_r[1])
			vec_nxt = vec1_r;
		else if (ext_live[2])
			vec_nxt = `VEC_DIRECT2;
		else if (ext_live[3])
			vec_nxt = `VEC_DIRECT3;
		else if (ext_live[1] & ~acknowledge_mode_select[1])
			vec_nxt = `VEC_DIRECT1;
		else if (ext_live[0] & ~acknowledge_mode_select[0])
			vec_nxt = `VEC_DIRECT0;
		else
		begin
			pend_nxt = 1'b0;
			for (i = CHANNELS - 1; i >= 0; i = i - 1)
				if (dma_irq[i])
				begin
					vec_nxt  = `VEC_DMA_BASE - i[7:0];
					pend_nxt = 1'b1;
				end
		end
	end

	assign irq_out = pend_nxt;

	// Register read data; end-of-service upper bits read zero.
	always @*
	begin
		reg_rdata = 32'h0000_0000;
		case (reg_addr)
		`OFF_INPUT_MASK:
			reg_rdata = {25'h0, err_mask_r, 2'b00, ext_mask_r};
		`OFF_ERROR_MASK:
			reg_rdata = {25'h0, err_mask_r, 6'h00};
		`OFF_PENDING_STATUS:
		begin
			reg_rdata[`POS_EXT_STATUS+3:`POS_EXT_STATUS] = ext_samp_r &
				{2'b11, ~acknowledge_mode_select};
			reg_rdata[`POS_ERR_STATUS] = err_samp_r;
			reg_rdata[CHANNELS-1:0] = dma_irq;
		end
		`OFF_EOS_ZERO:
			reg_rdata = {31'h0, eos_flag_r[0]};
		`OFF_EOS_ONE:
			reg_rdata = {31'h0, eos_flag_r[1]};
		`OFF_VECTOR:
			reg_rdata = {23'h0, pend_nxt, vec_nxt};
		default:
			reg_rdata = 32'h0000_0000;
		endcase
	end

	// Round-robin choice of the next DMA channel from the rotating pointer.
	assign dma_any = |(dma_request_line & ~dma_buffer_stop);
	generate
		for (g = 0; g < CHANNELS; g = g + 1)
		begin : rot_gen
			localparam [2:0] OFS = g;
			assign rot_elig[g] = dma_request_line[rr_ptr_r + OFS] &
				~dma_buffer_stop[rr_ptr_r + OFS];
		end
	endgenerate

	always @*
	begin
		pick_nxt = rr_ptr_r;
		pick_ok  = 1'b0;
		for (i = CHANNELS - 1; i >= 0; i = i - 1)
			if (rot_elig[i])
			begin
				pick_nxt = rr_ptr_r + i[2:0];
				pick_ok  = 1'b1;
			end
	end

	// Local and DMA requests must both be quiet for a full cycle before an acknowledge.
	always @(posedge clk_sys)
	begin
		if (rst)
			idle_seen_r <= 1'b0;
		else
			idle_seen_r <= ~local_req & ~dma_any;
	end

	// Grant is re-decided only when no cycle is running.
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			grant_r         <= `GNT_NONE;
			grant_channel_r <= 3'h0;
			rr_ptr_r        <= 3'h0;
			busy_r          <= 1'b0;
		end
		else
		begin
			if (busy_r & ~cycle_done)
				busy_r <= 1'b1;
			else if (local_req)
			begin
				grant_r <= `GNT_LOCAL;
				busy_r  <= 1'b1;
			end
			else if (busy_r & (grant_r == `GNT_DMA) &
				dma_request_line[grant_channel_r] & ~dma_buffer_stop[grant_channel_r])
				busy_r <= 1'b1;
			else if (pick_ok)
			begin
				grant_r         <= `GNT_DMA;
				grant_channel_r <= pick_nxt;
				rr_ptr_r        <= pick_nxt + 3'h1;
				busy_r          <= 1'b1;
			end
			else if (ack_req & idle_seen_r & ~dma_any)
			begin
				grant_r <= `GNT_ACK;
				busy_r  <= 1'b1;
			end
			else
			begin
				grant_r <= `GNT_NONE;
				busy_r  <= 1'b0;
			end
		end
	end
endmodule // aux_bus_interrupt_and_arbiter

// ==== sim/aux_intc_monitor.sv ====
// Port checks of the auxiliary interrupt block, bound to its top module.
`timescale 1ns/10ps
`include "aux_intc_consts.vh"
module aux_intc_monitor
#(
	parameter CHANNELS = 8
)
(
	input wire logic                clk_sys,
	input wire logic                rst,
	input wire logic                reg_rd,
	input wire logic                reg_wr,
	input wire logic [19:0]         reg_addr,
	input wire logic [31:0]         reg_rdata,
	input wire logic                reg_retry,
	input wire logic                posted_write_busy,
	input wire logic                irq_out,
	input wire logic                local_req,
	input wire logic [CHANNELS-1:0] dma_request_line,
	input wire logic [CHANNELS-1:0] dma_buffer_stop,
	input wire logic                cycle_done,
	input wire logic [1:0]          grant_r,
	input wire logic [2:0]          grant_channel_r
);
	wire logic eos = reg_addr == `OFF_EOS_ZERO || reg_addr == `OFF_EOS_ONE;
	wire logic idle = !local_req && (dma_request_line & ~dma_buffer_stop) == '0;
	wire logic keep = dma_request_line[grant_channel_r] && !dma_buffer_stop[grant_channel_r];
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_eos_retry: assert property ((reg_rd || reg_wr) && posted_write_busy && eos |-> reg_retry)
		else $error("eos not retried");
	chk_status_reserved: assert property (reg_addr == `OFF_PENDING_STATUS |->
		reg_rdata[31:24] == 8'h00 && reg_rdata[18:8] == 11'h000) else $error("status reserved");
	chk_vector_flag: assert property (reg_addr == `OFF_VECTOR |->
		reg_rdata[31:9] == 23'h0 && reg_rdata[8] == irq_out) else $error("vector flag");
	chk_eos_upper: assert property (eos |-> reg_rdata[31:1] == 31'h0)
		else $error("eos upper bits");
	chk_grant_stands: assert property (grant_r != `GNT_NONE && !cycle_done |=>
		$stable(grant_r) && $stable(grant_channel_r)) else $error("grant moved");
	chk_local_first: assert property (local_req && (grant_r == `GNT_NONE || cycle_done) |=>
		grant_r == `GNT_LOCAL) else $error("local not first");
	chk_dma_keeps: assert property (grant_r == `GNT_DMA && cycle_done && !local_req && keep |=>
		grant_r == `GNT_DMA && $stable(grant_channel_r)) else $error("dma lost bus");
	chk_ack_idle: assert property (grant_r == `GNT_ACK && $past(grant_r) != `GNT_ACK |->
		$past(idle) && $past(idle, 2)) else $error("ack while busy");
	cover property (grant_r == `GNT_ACK);
	cover property (reg_retry);
	cover property (grant_r == `GNT_DMA && cycle_done && keep);
endmodule // aux_intc_monitor
bind aux_bus_interrupt_and_arbiter aux_intc_monitor #(.CHANNELS(CHANNELS)) aux_intc_monitor_inst (.*);

// ==== sim/aux_far_side_model.sv ====
// Behavioural auxiliary bus devices that end granted cycles, promptly or slowly.
`timescale 1ns/10ps
`include "aux_intc_consts.vh"
module aux_far_side_model
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [1:0] grant_r,
	input  wire logic       slow,
	input  wire logic [7:0] vec_in,
	output logic            cycle_done,
	output logic            ack_vector_valid,
	output logic      [7:0] ack_vector
);
	logic [1:0] cnt_r = 2'h0;
	initial ack_vector = 8'h5A;
	always @(posedge clk_sys)
	begin
		cycle_done <= 1'b0;
		ack_vector_valid <= 1'b0;
		ack_vector <= ~ack_vector;
		cnt_r <= cnt_r + 2'h1;
		if (rst || grant_r == `GNT_NONE || cycle_done)
			cnt_r <= 2'h0;
		else if (cnt_r >= {slow, 1'b0})
		begin
			cycle_done <= 1'b1;
			ack_vector_valid <= grant_r == `GNT_ACK;
			ack_vector <= vec_in;
		end
	end
endmodule // aux_far_side_model

// ==== sim/tb.sv ====
// Self-checking bench with a reference model of the vector register of the auxiliary interrupt block.
`timescale 1ns/10ps
`include "aux_intc_consts.vh"
module tb;
	logic        clk_sys, rst, reg_rd, reg_wr, reg_retry, posted_write_busy, aux_error_input;
	logic        ack_vector_valid, irq_out, local_req, cycle_done, ack_req, slow, rt;
	logic [1:0]  acknowledge_mode_select, grant_r;
	logic [2:0]  grant_channel_r;
	logic [3:0]  aux_interrupt_inputs;
	logic [7:0]  dma_irq, ack_vector, dma_request_line, dma_buffer_stop, vec_in;
	logic [19:0] reg_addr, ea;
	logic [31:0] reg_wdata, reg_rdata, q, r, x;
	integer      seed = 32'hE034, bad_count = 0, n_compared = 0, cyc = 0, k, n;
	aux_bus_interrupt_and_arbiter #(.CHANNELS(8)) aux_bus_interrupt_and_arbiter_inst (.*);
	aux_far_side_model aux_far_side_model_inst (.*);
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task report_and_stop;
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count = bad_count + 1;
			report_and_stop;
		end
	end
	task ck(input string nm, input logic [31:0] e, input logic [31:0] a);
		n_compared = n_compared + 1;
		if (a !== e)
		begin
			bad_count = bad_count + 1;
			$display("[ERR] %s expected %h seen %h", nm, e, a);
		end
	endtask
	task acc(input logic rd, input logic [19:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		reg_rd <= rd;
		reg_wr <= !rd;
		reg_addr <= a;
		reg_wdata <= d;
		#4;
		q = reg_rdata;
		rt = reg_retry;
		@(negedge clk_sys);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
	endtask
	task rc(input string nm, input logic [19:0] a, input logic [31:0] e);
		acc(1'b1, a, 32'h0);
		ck(nm, e, q);
	endtask
	task wdone;
		do @(negedge clk_sys); while (!(cycle_done === 1'b1 && grant_r === `GNT_DMA));
	endtask
	function automatic logic [31:0] vexp(logic [3:0] a, logic e, logic [7:0] d);
		logic [7:0] v;
		v = `VEC_NONE;
		for (int c = 7; c >= 0; c--)
			if (d[c]) v = `VEC_DMA_BASE - c[7:0];
		if (a[0]) v = `VEC_DIRECT0;
		if (a[1]) v = `VEC_DIRECT1;
		if (a[3]) v = `VEC_DIRECT3;
		if (a[2]) v = `VEC_DIRECT2;
		if (e) v = `VEC_ERROR;
		return {23'h0, a != 4'h0 || e || d != 8'h00, v};
	endfunction
	initial
	begin
		{reg_rd, reg_wr, reg_addr, reg_wdata, posted_write_busy, aux_error_input} = '0;
		{aux_interrupt_inputs, acknowledge_mode_select, dma_irq, local_req} = '0;
		{dma_request_line, dma_buffer_stop, slow, vec_in} = '0;
		rst = 1'b1;
		repeat (12) @(negedge clk_sys);
		rst <= 1'b0;
		rc("imask", `OFF_INPUT_MASK, 32'h0);
		rc("vector", `OFF_VECTOR, 32'h0);
		{aux_interrupt_inputs, aux_error_input} <= 5'h1F;
		repeat (3) @(negedge clk_sys);
		ck("irq", 32'h0, irq_out);
		acc(1'b0, `OFF_INPUT_MASK, 32'h4F);
		repeat (3) @(negedge clk_sys);
		ck("irq", 32'h1, irq_out);
		rc("emask", `OFF_ERROR_MASK, 32'h40);
		acc(1'b0, `OFF_ERROR_MASK, 32'h0);
		rc("imask", `OFF_INPUT_MASK, 32'h0F);
		acc(1'b0, `OFF_ERROR_MASK, 32'h40);
		for (k = 0; k < 8; k++)
		begin
			r = $random(seed);
			{aux_interrupt_inputs, aux_error_input, dma_irq} <= r[12:0];
			repeat (3) @(negedge clk_sys);
			x = vexp(aux_interrupt_inputs, aux_error_input, dma_irq);
			ck("irq", {31'h0, x[8]}, irq_out);
			rc("vector", `OFF_VECTOR, x);
			rc("status", `OFF_PENDING_STATUS, {8'h0, r[12:8], 11'h0, r[7:0]});
		end
		{aux_interrupt_inputs, aux_error_input, dma_irq} <= 13'h0;
		for (n = 0; n < 2; n++)
		begin
			ea = n ? `OFF_EOS_ONE : `OFF_EOS_ZERO;
			acknowledge_mode_select <= 2'b01 << n;
			{slow, vec_in} <= {n[0], 8'h35 + n[7:0]};
			aux_interrupt_inputs <= 4'h1 << n;
			repeat (20) @(negedge clk_sys);
			rc("vector", `OFF_VECTOR, 32'h135 + n);
			ck("ackreq", 32'h0, {31'h0, ack_req});
			aux_interrupt_inputs <= 4'h0;
			posted_write_busy <= 1'b1;
			acc(1'b1, ea, 32'h0);
			ck("retry", 32'h1, {31'h0, rt});
			posted_write_busy <= 1'b0;
			acc(n == 0, ea, 32'hFFFFFFFF);
			ck("eos", 32'h1, q);
			rc("eos", ea, 32'h0);
			vec_in <= `VEC_DISCARD;
			aux_interrupt_inputs <= 4'h1 << n;
			repeat (20) @(negedge clk_sys);
			ck("irq", 32'h0, irq_out);
			aux_interrupt_inputs <= 4'h0;
			repeat (10) @(negedge clk_sys);
			rc("eos", ea, 32'h0);
		end
		dma_request_line <= 8'h09;
		for (k = 0; k < 4; k++)
		begin
			dma_buffer_stop <= k == 0 ? 8'h00 : (k[0] ? 8'h01 : 8'h08);
			repeat (2) wdone;
			ck("channel", k[0] ? 32'h3 : 32'h0, {29'h0, grant_channel_r});
		end
		aux_interrupt_inputs <= 4'h1;
		for (k = 0; k < 400; k++)
		begin
			r = $random(seed);
			local_req <= r[2:0] == 3'h0 && r[6];
			dma_request_line <= r[15:8] & r[23:16] & {8{r[5]}};
			dma_buffer_stop <= r[31:24] & {8{r[3]}};
			slow <= r[4];
			@(negedge clk_sys);
		end
		report_and_stop;
	end
endmodule // tb
